// File: logic/dcb_channel.sv
/*
  One DMA channel moving a block from a source area to a destination area.
  Registers sit on a classic Wishbone slave; data moves over a classic
  Wishbone master through a 32-word buffer.
  Assumes one system clock, synchronous reset, and a memory bus that always
  acknowledges eventually.
*/
// The Wishbone slave port is this design's own decision.
// Overview of operation
// - source address register, read side
// - destination address register, write side
// - transfer count register loaded by software
// - enable bit 31 gates all transfers
// - size field 00 means byte accesses
// - mode field 00 means normal transfer
// - request field 00 means auto request
// - scheme bit: 0 dual, 1 single address
// - source step 10 increments per unit
// - destination step 10 increments per unit
// - module stop holds the channel stopped
// - channel runs on the system clock
`timescale 1ns/1ps
module dcb_channel #(
  parameter int FIFO_W = dcb_pkg::FIFO_WIDTH,
  parameter int FIFO_D = dcb_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [23:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             mem_cyc_o,
  output logic             mem_stb_o,
  output logic             mem_we_o,
  output logic      [31:0] mem_adr_o,
  output logic      [3:0]  mem_sel_o,
  output logic      [31:0] mem_dat_o,
  input  wire logic [31:0] mem_dat_i,
  input  wire logic        mem_ack_i
);

  localparam int AW = $clog2(FIFO_D);
  localparam int LW = $clog2(FIFO_D + 1);

  // byte lanes of one unit, by size and low address bits
  function automatic logic [3:0] lane_sel(input logic [1:0] size, input logic [1:0] a);
    logic [3:0] s;
    s = 4'h0;
    unique case (size)
      dcb_pkg::SIZE_BYTE: s = 4'h1 << a;
      dcb_pkg::SIZE_WORD: s = a[1] ? 4'hc : 4'h3;
      default:            s = 4'hf;
    endcase
    return s;
  endfunction : lane_sel

  // next address after one unit; unknown step codes keep the address fixed
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] step,
                                            input logic [1:0] size);
    logic [31:0] inc;
    inc = (size == dcb_pkg::SIZE_BYTE) ? 32'h1 : (size == dcb_pkg::SIZE_WORD) ? 32'h2 : 32'h4;
    if (step == dcb_pkg::STEP_INC) begin
      return a + inc;
    end else if (step == dcb_pkg::STEP_DEC) begin
      return a - inc;
    end
    return a;
  endfunction : step_addr

  // byte-enable merge of a bus write into a register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = d[8*i +: 8];
    end
    return r;
  endfunction : merge

  logic [31:0]         src_reg;
  logic [31:0]         dst_reg;
  logic [31:0]         count_reg;
  logic [31:0]         mode_reg;
  logic [31:0]         actl_reg;
  logic                stop_reg;
  logic                wb_ack_reg;
  logic [31:0]         wb_dat_reg;
  dcb_pkg::dcb_state_t state_reg;
  logic                mem_cyc_reg;
  logic                mem_we_reg;
  logic [31:0]         mem_adr_reg;
  logic [3:0]          mem_sel_reg;
  logic [31:0]         mem_dat_reg;

  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic [FIFO_W-1:0]   fifo_out_data;
  logic [LW-1:0]       fifo_level;
  logic                ram_we;
  logic [AW-1:0]       ram_waddr;
  logic [FIFO_W-1:0]   ram_wdata;
  logic                ram_re;
  logic [AW-1:0]       ram_raddr;
  logic [FIFO_W-1:0]   ram_rdata;

  // register bus decode; writes land on the edge that sees ack high
  wire        wb_req      = wb_cyc_i && wb_stb_i;
  wire        wb_wr       = wb_req && wb_we_i && wb_ack_reg;
  wire        hit_src     = wb_adr_i == dcb_pkg::SRC_ADDR_OFS;
  wire        hit_dst     = wb_adr_i == dcb_pkg::DST_ADDR_OFS;
  wire        hit_count   = wb_adr_i == dcb_pkg::COUNT_OFS;
  wire        hit_mode    = wb_adr_i == dcb_pkg::MODE_CTRL_OFS;
  wire        hit_actl    = wb_adr_i == dcb_pkg::ADDR_CTRL_OFS;
  wire        hit_stop    = wb_adr_i == dcb_pkg::STOP_CTRL_OFS;
  wire        hit_status  = wb_adr_i == dcb_pkg::STATUS_OFS;
  wire [31:0] status_word = {24'h00_0000, (state_reg != dcb_pkg::ST_IDLE),
                             (7 - LW)'(0), fifo_level};
  wire [31:0] rd_mux      = hit_src    ? src_reg   :
                            hit_dst    ? dst_reg   :
                            hit_count  ? count_reg :
                            hit_mode   ? mode_reg  :
                            hit_actl   ? actl_reg  :
                            hit_stop   ? {31'h0000_0000, stop_reg} :
                            hit_status ? status_word : 32'h0000_0000;

  // decoded fields
  wire [1:0]  size      = mode_reg[dcb_pkg::SIZE_HI:dcb_pkg::SIZE_LO];
  wire [1:0]  xmode     = mode_reg[dcb_pkg::XMODE_HI:dcb_pkg::XMODE_LO];
  wire [1:0]  req_src   = mode_reg[dcb_pkg::REQ_HI:dcb_pkg::REQ_LO];
  wire        enable    = mode_reg[dcb_pkg::ENABLE_BIT];
  wire        single    = actl_reg[dcb_pkg::SCHEME_BIT];
  wire [1:0]  src_step  = actl_reg[dcb_pkg::SRC_STEP_HI:dcb_pkg::SRC_STEP_LO];
  wire [1:0]  dst_step  = actl_reg[dcb_pkg::DST_STEP_HI:dcb_pkg::DST_STEP_LO];

  // only normal mode with auto request is built; other codes leave it parked
  wire        run_ok    = enable && !stop_reg
                          && xmode == dcb_pkg::XMODE_NORMAL
                          && req_src == dcb_pkg::REQ_AUTO;
  wire        idle      = state_reg == dcb_pkg::ST_IDLE;
  wire        reads_due = count_reg > 32'(fifo_level);
  wire        start_rd  = idle && run_ok && reads_due && fifo_in_ready;
  wire        start_wr  = idle && run_ok && !start_rd && fifo_out_valid && !single;
  wire        rd_ack    = state_reg == dcb_pkg::ST_READ && mem_ack_i;
  wire        wr_ack    = state_reg == dcb_pkg::ST_WRITE && mem_ack_i;
  wire        unit_done = single ? rd_ack : wr_ack;
  wire        last_unit = unit_done && count_reg == 32'h0000_0001;
  wire        zero_end  = idle && enable && count_reg == 32'h0000_0000;
  wire [31:0] rd_shift  = mem_dat_i >> {mem_adr_reg[1:0], 3'b000};
  wire [31:0] rd_unit   = (size == dcb_pkg::SIZE_BYTE) ? {24'h00_0000, rd_shift[7:0]} :
                          (size == dcb_pkg::SIZE_WORD) ? {16'h0000, rd_shift[15:0]} : rd_shift;
  wire [31:0] wr_lanes  = (size == dcb_pkg::SIZE_BYTE) ? {4{fifo_out_data[7:0]}} :
                          (size == dcb_pkg::SIZE_WORD) ? {2{fifo_out_data[15:0]}} :
                          fifo_out_data;

  assign wb_ack_o  = wb_ack_reg;
  assign wb_dat_o  = wb_dat_reg;
  assign mem_cyc_o = mem_cyc_reg;
  assign mem_stb_o = mem_cyc_reg;
  assign mem_we_o  = mem_we_reg;
  assign mem_adr_o = mem_adr_reg;
  assign mem_sel_o = mem_sel_reg;
  assign mem_dat_o = mem_dat_reg;

  // slave answers one cycle after the request and drops ack the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0000_0000;
    end else begin
      wb_ack_reg <= wb_req && !wb_ack_reg;
      wb_dat_reg <= (wb_req && !wb_ack_reg && !wb_we_i) ? rd_mux : 32'h0000_0000;
    end
  end

  // address registers: software write wins over the hardware step
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_reg <= dcb_pkg::REG_RESET;
      dst_reg <= dcb_pkg::REG_RESET;
    end else begin
      if (wb_wr && hit_src) begin
        src_reg <= merge(src_reg, wb_dat_i, wb_sel_i);
      end else if (rd_ack) begin
        src_reg <= step_addr(src_reg, src_step, size);
      end
      if (wb_wr && hit_dst) begin
        dst_reg <= merge(dst_reg, wb_dat_i, wb_sel_i);
      end else if (wr_ack) begin
        dst_reg <= step_addr(dst_reg, dst_step, size);
      end
    end
  end

  // count and control; a software write to enable in the end cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= dcb_pkg::REG_RESET;
      mode_reg  <= dcb_pkg::REG_RESET;
      actl_reg  <= dcb_pkg::REG_RESET;
      stop_reg  <= dcb_pkg::STOP_RESET;
    end else begin
      if (wb_wr && hit_count) begin
        count_reg <= merge(count_reg, wb_dat_i, wb_sel_i);
      end else if (unit_done) begin
        count_reg <= count_reg - 32'h0000_0001;
      end
      if (wb_wr && hit_mode) begin
        mode_reg <= merge(mode_reg, wb_dat_i, wb_sel_i);
      end else if (last_unit || zero_end) begin
        mode_reg[dcb_pkg::ENABLE_BIT] <= 1'b0;
      end
      if (wb_wr && hit_actl) begin
        actl_reg <= merge(actl_reg, wb_dat_i, wb_sel_i);
      end
      if (wb_wr && hit_stop && wb_sel_i[0]) begin
        stop_reg <= wb_dat_i[0];
      end
    end
  end

  // sequencer: an access always completes, so a stop only acts between units
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= dcb_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        dcb_pkg::ST_IDLE: begin
          if (start_rd) begin
            state_reg <= dcb_pkg::ST_READ;
          end else if (start_wr) begin
            state_reg <= dcb_pkg::ST_WRITE;
          end
        end
        dcb_pkg::ST_READ: begin
          if (mem_ack_i) state_reg <= dcb_pkg::ST_IDLE;
        end
        dcb_pkg::ST_WRITE: begin
          if (mem_ack_i) state_reg <= dcb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // master request: reads fill the buffer first, writes drain it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_cyc_reg <= 1'b0;
      mem_we_reg  <= 1'b0;
      mem_adr_reg <= 32'h0000_0000;
      mem_sel_reg <= 4'h0;
      mem_dat_reg <= 32'h0000_0000;
    end else if (start_rd) begin
      mem_cyc_reg <= 1'b1;
      mem_we_reg  <= 1'b0;
      mem_adr_reg <= src_reg;
      mem_sel_reg <= lane_sel(size, src_reg[1:0]);
    end else if (start_wr) begin
      mem_cyc_reg <= 1'b1;
      mem_we_reg  <= 1'b1;
      mem_adr_reg <= dst_reg;
      mem_sel_reg <= lane_sel(size, dst_reg[1:0]);
      mem_dat_reg <= wr_lanes << {dst_reg[1:0], 3'b000};
    end else if (mem_ack_i && mem_cyc_reg) begin
      mem_cyc_reg <= 1'b0;
      mem_we_reg  <= 1'b0;
    end
  end

  // the write start pops the word it carries, so data order is kept
  dcb_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (rd_ack && !single),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rd_unit[FIFO_W-1:0]),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (start_wr),
    .out_data_o  (fifo_out_data),
    .level_o     (fifo_level),
    .ram_we_o    (ram_we),
    .ram_waddr_o (ram_waddr),
    .ram_wdata_o (ram_wdata),
    .ram_re_o    (ram_re),
    .ram_raddr_o (ram_raddr),
    .ram_rdata_i (ram_rdata)
  );

  dcb_ram #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_ram (
    .clk_i   (clk_i),
    .we_i    (ram_we),
    .waddr_i (ram_waddr),
    .wdata_i (ram_wdata),
    .re_i    (ram_re),
    .raddr_i (ram_raddr),
    .rdata_o (ram_rdata)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence rd_unit_s;
    state_reg == dcb_pkg::ST_READ && mem_ack_i;
  endsequence

  sequence wr_unit_s;
    state_reg == dcb_pkg::ST_WRITE && mem_ack_i;
  endsequence

  chk_src_incr: assert property ((rd_unit_s ##0 (src_step == dcb_pkg::STEP_INC
      && size == dcb_pkg::SIZE_BYTE && !(wb_wr && hit_src))) |=> src_reg == $past(src_reg) + 1)
    else $error("source address did not step by one");
  chk_dst_incr: assert property ((wr_unit_s ##0 (dst_step == dcb_pkg::STEP_INC
      && size == dcb_pkg::SIZE_BYTE && !(wb_wr && hit_dst))) |=> dst_reg == $past(dst_reg) + 1)
    else $error("destination address did not step by one");
  chk_count_step: assert property ((wr_unit_s ##0 (!single && !(wb_wr && hit_count)))
      |=> count_reg == $past(count_reg) - 1)
    else $error("count did not drop by one per unit");
  chk_end_clear: assert property ((last_unit && !(wb_wr && hit_mode)) |=> !enable)
    else $error("enable not cleared at block end");
  chk_gate_idle: assert property ((idle && !run_ok) |=> !mem_cyc_o)
    else $error("access started while gated");
  chk_stop_holds: assert property ((idle && stop_reg) [*2] |-> !mem_cyc_o)
    else $error("access while module stopped");
  chk_read_addr: assert property ($rose(mem_cyc_o) && !mem_we_o |-> mem_adr_o == $past(src_reg))
    else $error("read not at source address");
  chk_write_addr: assert property ($rose(mem_cyc_o) && mem_we_o |-> mem_adr_o == $past(dst_reg))
    else $error("write not at destination address");
  chk_byte_lane: assert property (mem_cyc_o && size == dcb_pkg::SIZE_BYTE |-> $onehot(mem_sel_o))
    else $error("byte unit drove several lanes");
  chk_write_sourced: assert property ($rose(mem_cyc_o && mem_we_o) |-> $past(fifo_out_valid))
    else $error("write with no data read");
  chk_single_nowrite: assert property (idle && single |=> !(mem_cyc_o && mem_we_o))
    else $error("single mode issued a write");
  chk_auto_only: assert property (idle && (xmode != 2'h0 || req_src != 2'h0) |=> !mem_cyc_o)
    else $error("unsupported mode started a transfer");
  chk_bus_ack: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack held two cycles");

endmodule : dcb_channel

// File: logic/dcb_pkg.sv
/*
  Shared constants for the block-transfer DMA channel: register byte addresses,
  field positions, field encodings, reset values, buffer sizes and the
  sequencer states.
  Assumes nothing; included by name only, never imported.
*/
package dcb_pkg;

  // register byte addresses on the 24-bit register bus
  localparam int          REG_ADDR_W        = 24;
  localparam logic [23:0] SRC_ADDR_OFS      = 24'hfffc00;
  localparam logic [23:0] DST_ADDR_OFS      = 24'hfffc04;
  localparam logic [23:0] COUNT_OFS         = 24'hfffc0c;
  localparam logic [23:0] MODE_CTRL_OFS     = 24'hfffc14;
  localparam logic [23:0] ADDR_CTRL_OFS     = 24'hfffc18;
  localparam logic [23:0] STOP_CTRL_OFS     = 24'hfffc1c;
  localparam logic [23:0] STATUS_OFS        = 24'hfffc20;

  // mode control fields
  localparam int          ENABLE_BIT        = 31;
  localparam int          SIZE_HI           = 15;
  localparam int          SIZE_LO           = 14;
  localparam int          XMODE_HI          = 13;
  localparam int          XMODE_LO          = 12;
  localparam int          REQ_HI            = 7;
  localparam int          REQ_LO            = 6;

  // address control fields
  localparam int          SCHEME_BIT        = 31;
  localparam int          SRC_STEP_HI       = 21;
  localparam int          SRC_STEP_LO       = 20;
  localparam int          DST_STEP_HI       = 17;
  localparam int          DST_STEP_LO       = 16;

  // field encodings
  localparam logic [1:0]  SIZE_BYTE         = 2'h0;
  localparam logic [1:0]  SIZE_WORD         = 2'h1;
  localparam logic [1:0]  SIZE_LONG         = 2'h2;
  localparam logic [1:0]  XMODE_NORMAL      = 2'h0;
  localparam logic [1:0]  REQ_AUTO          = 2'h0;
  localparam logic [1:0]  STEP_INC          = 2'h2;
  localparam logic [1:0]  STEP_DEC          = 2'h3;

  // values after reset
  localparam logic [31:0] REG_RESET         = 32'h0000_0000;
  localparam logic        STOP_RESET        = 1'b1;

  // data buffer
  localparam int          FIFO_WIDTH        = 32;
  localparam int          FIFO_DEPTH        = 32;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dcb_state_t;

endpackage : dcb_pkg

// File: logic/dcb_ram.sv
/*
  Simple dual-port storage for the channel's data buffer; read data comes out
  of a register one cycle after the read enable.
  Assumes one clock and a single writer and reader.
*/
`timescale 1ns/1ps
module dcb_ram #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  input  wire logic             re_i,
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // storage has no reset; contents are only read after being written
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    if (re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule : dcb_ram

// File: logic/dcb_fifo.sv
/*
  Pointer and flow control for the channel's data buffer, with a registered
  output stage fed from an external storage module.
  Assumes DEPTH is a power of two and the storage answers one cycle late.
*/
`timescale 1ns/1ps
module dcb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH),
  parameter int LW    = $clog2(DEPTH + 1)
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  output logic      [LW-1:0]    level_o,
  output logic                  ram_we_o,
  output logic      [AW-1:0]    ram_waddr_o,
  output logic      [WIDTH-1:0] ram_wdata_o,
  output logic                  ram_re_o,
  output logic      [AW-1:0]    ram_raddr_o,
  input  wire logic [WIDTH-1:0] ram_rdata_i
);

  logic [LW-1:0] cnt_reg;
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic          oval_reg;
  wire           push  = in_valid_i && in_ready_o;
  wire           fetch = (cnt_reg != '0) && (!oval_reg || out_ready_i);

  // total occupancy counts the output stage, so full means DEPTH words held
  assign level_o     = cnt_reg + LW'(oval_reg);
  assign in_ready_o  = level_o < LW'(DEPTH);
  assign out_valid_o = oval_reg;
  assign out_data_o  = ram_rdata_i;
  assign ram_we_o    = push;
  assign ram_waddr_o = wp_reg;
  assign ram_wdata_o = in_data_i;
  assign ram_re_o    = fetch;
  assign ram_raddr_o = rp_reg;

  // pointers advance on push and fetch; output stage reloads when drained
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg  <= '0;
      wp_reg   <= '0;
      rp_reg   <= '0;
      oval_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_reg + LW'(push) - LW'(fetch);
      wp_reg   <= wp_reg + AW'(push);
      rp_reg   <= rp_reg + AW'(fetch);
      oval_reg <= fetch || (oval_reg && !out_ready_i);
    end
  end

endmodule : dcb_fifo

// File: verification/dcb_mem_model.sv
/*
  Behavioural byte memory on the channel's Wishbone master side.
  Assumes the channel holds its request until ack; the bench sets the delay.
*/
`timescale 1ns/1ps
module dcb_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  delay_i,
  output logic      [31:0] dat_o,
  output logic             ack_o
);
  logic [7:0]  mem [0:4095];
  logic [31:0] rdata_reg = 32'h0;
  logic [3:0]  wait_reg  = 4'h0;
  int          rd_count  = 0;
  int          wr_count  = 0;
  wire  [11:0] base      = {adr_i[11:2], 2'b00};

  // released lines show the inverse, so stale data never passes for fresh
  assign dat_o = ack_o ? rdata_reg : ~rdata_reg;

  // answer after delay_i wait cycles; a write lands only at its ack edge
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    if (rst_i) begin
      wait_reg <= 4'h0;
    end else if (cyc_i && stb_i && !ack_o) begin
      if (wait_reg == delay_i) begin
        ack_o     <= 1'b1;
        wait_reg  <= 4'h0;
        rdata_reg <= {mem[base+3], mem[base+2], mem[base+1], mem[base]};
        if (we_i) begin
          wr_count <= wr_count + 1;
          for (int i = 0; i < 4; i++) begin
            if (sel_i[i]) begin
              mem[base+i] <= dat_i[8*i +: 8];
            end
          end
        end else begin
          rd_count <= rd_count + 1;
        end
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule : dcb_mem_model

// File: verification/dcb_channel_bench.sv
/*
  Self-checking bench for the DMA channel: register tasks on Wishbone, then
  block moves against the memory model.
  Assumes the channel acks each register access and its memory bus completes.
*/
`timescale 1ns/1ps
module dcb_channel_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [23:0] adr   = 24'h0;
  logic [31:0] dat   = 32'h0;
  logic [3:0]  dly   = 4'h0;
  logic [31:0] wb_dat_o, mem_adr_o, mem_dat_o, mem_dat_i;
  logic        wb_ack_o, mem_cyc_o, mem_stb_o, mem_we_o, mem_ack_i;
  logic [3:0]  mem_sel_o;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          rd0;

  dcb_channel u_dcb_channel (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mem_cyc_o(mem_cyc_o), .mem_stb_o(mem_stb_o), .mem_we_o(mem_we_o),
    .mem_adr_o(mem_adr_o), .mem_sel_o(mem_sel_o), .mem_dat_o(mem_dat_o),
    .mem_dat_i(mem_dat_i), .mem_ack_i(mem_ack_i));
  dcb_mem_model u_dcb_mem_model (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(mem_cyc_o),
    .stb_i(mem_stb_o), .we_i(mem_we_o), .adr_i(mem_adr_o), .sel_i(mem_sel_o),
    .dat_i(mem_dat_o), .delay_i(dly), .dat_o(mem_dat_i), .ack_o(mem_ack_i));

  // 20 MHz system clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic stop_test();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one classic cycle; ack and read data are taken at the rising edge that sees ack
  task automatic io(input logic w, input logic [23:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 50);
    q = wb_dat_o;
    // a missing ack is a mismatch, not a silent pass
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      $display("Error register ack expected 1 seen %b", wb_ack_o);
    end
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask : io

  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    logic [31:0] q;
    io(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [23:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    io(1'b0, a, 32'h0, q);
    chk(nm, exp, q);
  endtask : rd

  // poll until the channel clears its own enable bit, bounded
  task automatic wait_done();
    logic [31:0] q;
    int n;
    n = 0;
    do io(1'b0, dcb_pkg::MODE_CTRL_OFS, 32'h0, q); while (q[31] !== 1'b0 && ++n < 300);
    if (q[31] !== 1'b0) begin
      bad_count++;
      $display("Error enable expected 0 seen %b", q[31]);
    end
  endtask : wait_done

  // watchdog: the whole run needs a few hundred cycles
  initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end

  initial begin
    for (int i = 0; i < 64; i++) u_dcb_mem_model.mem[12'h100 + i] = 8'h80 + 8'(i);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(dcb_pkg::SRC_ADDR_OFS, 32'h0, "src");
    rd(dcb_pkg::DST_ADDR_OFS, 32'h0, "dst");
    rd(dcb_pkg::COUNT_OFS, 32'h0, "count");
    rd(dcb_pkg::MODE_CTRL_OFS, 32'h0, "mode");
    rd(dcb_pkg::ADDR_CTRL_OFS, 32'h0, "actl");
    rd(dcb_pkg::STOP_CTRL_OFS, 32'h1, "stop");
    rd(24'hfffc10, 32'h0, "unmapped");
    // dual mode, byte units, both addresses stepping up, slow memory
    dly <= 4'h2;
    wr(dcb_pkg::SRC_ADDR_OFS, 32'h100);
    wr(dcb_pkg::DST_ADDR_OFS, 32'h200);
    wr(dcb_pkg::COUNT_OFS, 32'h8);
    wr(dcb_pkg::ADDR_CTRL_OFS, 32'h0022_0000);
    wr(dcb_pkg::MODE_CTRL_OFS, 32'h8000_0000);
    repeat (20) @(posedge clk_i);
    chk("stopped reads", 32'h0, u_dcb_mem_model.rd_count);
    rd(dcb_pkg::COUNT_OFS, 32'h8, "held count");
    wr(dcb_pkg::STOP_CTRL_OFS, 32'h0);
    wait_done();
    rd(dcb_pkg::COUNT_OFS, 32'h0, "end count");
    rd(dcb_pkg::SRC_ADDR_OFS, 32'h108, "src end");
    rd(dcb_pkg::DST_ADDR_OFS, 32'h208, "dst end");
    rd(dcb_pkg::STATUS_OFS, 32'h0, "status end");
    chk("byte reads", 32'h8, u_dcb_mem_model.rd_count);
    chk("byte writes", 32'h8, u_dcb_mem_model.wr_count);
    for (int i = 0; i < 8; i++) chk("dst byte", 32'h80 + i, u_dcb_mem_model.mem[12'h200 + i]);
    chk("past end", 32'h0, u_dcb_mem_model.mem[12'h208] === 8'h88);
    // other mode and request fields must not move data
    dly <= 4'h0;
    rd0 = u_dcb_mem_model.rd_count;
    wr(dcb_pkg::COUNT_OFS, 32'h4);
    wr(dcb_pkg::MODE_CTRL_OFS, 32'h8000_1000);
    repeat (20) @(posedge clk_i);
    chk("mode 01 reads", rd0, u_dcb_mem_model.rd_count);
    wr(dcb_pkg::MODE_CTRL_OFS, 32'h8000_0040);
    repeat (20) @(posedge clk_i);
    chk("request 01 reads", rd0, u_dcb_mem_model.rd_count);
    // single address mode: reads only, source still steps
    wr(dcb_pkg::MODE_CTRL_OFS, 32'h0);
    wr(dcb_pkg::ADDR_CTRL_OFS, 32'h8022_0000);
    wr(dcb_pkg::SRC_ADDR_OFS, 32'h300);
    wr(dcb_pkg::MODE_CTRL_OFS, 32'h8000_0000);
    wait_done();
    chk("single reads", rd0 + 4, u_dcb_mem_model.rd_count);
    chk("single writes", 32'h8, u_dcb_mem_model.wr_count);
    rd(dcb_pkg::SRC_ADDR_OFS, 32'h304, "single src");
    stop_test();
  end
endmodule : dcb_channel_bench
